// File: core/asc_pkg.sv
// constants shared by the start-up and chop sequencer
package asc_pkg;
	localparam int unsigned INIT_WAIT_PERIODS = 256;
	localparam int unsigned LEAD_PERIODS      = 44;
	localparam int unsigned DEFAULT_OSR       = 1024;
	localparam int unsigned CHOP_CONV_MULT    = 3;
	localparam int unsigned FAST_SAMPLES      = 2;
	localparam int unsigned CHOP_PAIR_MIN     = 2;
	localparam int unsigned CNT_W             = 24;
	localparam int unsigned OSR_W             = 15;
	localparam int unsigned DLY_FIELD_W       = 4;
	localparam int unsigned DLY_BASE_SHIFT    = 1;
	localparam int unsigned RST_MIN_W_CYCLES  = 64;
	localparam int unsigned DATA_READY_N_LOW_CYCLES   = 8;

	typedef enum logic [2:0] {
		ASC_POR   = 3'h0,
		ASC_HOLD  = 3'h1,
		ASC_INIT  = 3'h2,
		ASC_LEAD  = 3'h3,
		ASC_CONT  = 3'h4,
		ASC_CDLY  = 3'h5,
		ASC_CCONV = 3'h6
	} asc_state_t;
endpackage : asc_pkg

// File: core/asc_sequencer.sv
// start-up, continuous and chop conversion sequencer
`timescale 1ns/1ps
module asc_sequencer #(
	parameter int unsigned OSR_RESET = asc_pkg::DEFAULT_OSR,
	parameter int unsigned RST_MIN_W = asc_pkg::RST_MIN_W_CYCLES,
	parameter int unsigned DATA_READY_N_W    = asc_pkg::DATA_READY_N_LOW_CYCLES
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          master_clock_in,
	input  wire logic                          sync_reset_n,
	input  wire logic                          supply_settled,
	input  wire logic                          command_reset,
	input  wire logic                          chop_enable_bit,
	input  wire logic [asc_pkg::DLY_FIELD_W-1:0] chop_settle_delay_field,
	input  wire logic [asc_pkg::OSR_W-1:0]     osr,
	input  wire logic                          phase_cal_request,
	input  wire logic                          test_signal_request,
	output logic                               data_ready_n,
	output logic                               modulator_run,
	output logic                               fast_path_enable,
	output logic                               sinc_path_select,
	output logic                               chop_polarity,
	output logic                               filter_reset,
	output logic                               pair_average,
	output logic                               result_strobe,
	output logic                               phase_cal_active,
	output logic                               test_signal_active
);
	localparam int unsigned CW = asc_pkg::CNT_W;

	logic                 mck_s1_q, mck_s2_q, mck_s3_q;
	logic                 syn_s1_q, syn_s2_q, syn_s3_q;
	logic                 mod_tick;
	logic                 sync_fall;
	logic [CW-1:0]        low_cnt_q;
	logic                 pin_rst_q;
	logic                 in_por;
	logic                 go_hold;
	logic                 go_lead;
	logic                 step;
	logic                 cont_out;
	logic                 chop_swap;
	asc_pkg::asc_state_t  state_d;
	asc_pkg::asc_state_t  state_q;
	logic [CW-1:0]        cnt_q;
	logic [CW-1:0]        target;
	logic [CW-1:0]        chop_dly;
	logic [CW-1:0]        conv_len;
	logic                 done;
	logic [1:0]           out_cnt_q;
	logic [1:0]           pair_cnt_q;
	logic [asc_pkg::OSR_W-1:0] osr_q;
	logic                 chop_q;
	logic                 restart;
	logic [CW-1:0]        data_ready_n_cnt_q;
	logic                 result_d;

	// two-flop synchronisers, third stage for edge detection only
	always_ff @(posedge mclk) begin
		if (rst) begin
			mck_s1_q <= 1'b0;
			mck_s2_q <= 1'b0;
			mck_s3_q <= 1'b0;
		end else begin
			mck_s1_q <= master_clock_in;
			mck_s2_q <= mck_s1_q;
			mck_s3_q <= mck_s2_q;
		end
	end

	// sync pin idles high, so its stages reset high to avoid a false fall
	always_ff @(posedge mclk) begin
		if (rst) begin
			syn_s1_q <= 1'b1;
			syn_s2_q <= 1'b1;
			syn_s3_q <= 1'b1;
		end else begin
			syn_s1_q <= sync_reset_n;
			syn_s2_q <= syn_s1_q;
			syn_s3_q <= syn_s2_q;
		end
	end

	// one tick per modulator period; no ticks while the clock stands still
	assign mod_tick  = mck_s2_q & ~mck_s3_q;
	assign sync_fall = syn_s3_q & ~syn_s2_q;

	// long low on the sync pin becomes a held reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			low_cnt_q <= '0;
			pin_rst_q <= 1'b0;
		end else if (syn_s2_q) begin
			low_cnt_q <= '0;
			pin_rst_q <= 1'b0;
		end else if (low_cnt_q >= CW'(RST_MIN_W)) begin
			pin_rst_q <= 1'b1;
		end else begin
			low_cnt_q <= low_cnt_q + CW'(1);
		end
	end

	// settle delay is a power of two: field 0 gives 2, field 15 gives 65536
	assign chop_dly = CW'(1) << (CW'(chop_settle_delay_field) + CW'(asc_pkg::DLY_BASE_SHIFT));
	assign conv_len = CW'(asc_pkg::CHOP_CONV_MULT) * CW'(osr);

	always_comb begin
		case (state_q)
			asc_pkg::ASC_INIT:  target = CW'(asc_pkg::INIT_WAIT_PERIODS);
			asc_pkg::ASC_LEAD:  target = CW'(asc_pkg::LEAD_PERIODS);
			asc_pkg::ASC_CONT:  target = CW'(osr);
			asc_pkg::ASC_CDLY:  target = chop_dly;
			asc_pkg::ASC_CCONV: target = conv_len;
			default:            target = '0;
		endcase
	end

	assign done    = mod_tick && (cnt_q + CW'(1) >= target);
	assign restart = chop_q && (sync_fall || osr != osr_q || !chop_enable_bit);

	always_ff @(posedge mclk) begin
		if (rst) begin
			osr_q <= asc_pkg::OSR_W'(OSR_RESET);
		end else begin
			osr_q <= osr;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			chop_q <= 1'b0;
		end else begin
			chop_q <= chop_enable_bit && state_q != asc_pkg::ASC_POR;
		end
	end

	// event decode shared by the per-concern registers below
	// a restart is ignored during the start-up waits, which end in a lead-in anyway
	assign in_por    = state_q == asc_pkg::ASC_POR;
	assign go_hold   = !in_por && (pin_rst_q || command_reset);
	assign go_lead   = !in_por && !go_hold && restart && state_q != asc_pkg::ASC_HOLD
		&& state_q != asc_pkg::ASC_INIT && state_q != asc_pkg::ASC_LEAD;
	assign step      = !in_por && !go_hold && !go_lead && state_q != asc_pkg::ASC_HOLD && done;
	assign cont_out  = step && state_q == asc_pkg::ASC_CONT;
	assign chop_swap = step && state_q == asc_pkg::ASC_CCONV;

	always_comb begin
		state_d = state_q;
		if (in_por) begin
			if (supply_settled) begin
				state_d = asc_pkg::ASC_INIT;
			end
		end else if (go_hold) begin
			state_d = asc_pkg::ASC_HOLD;
		end else if (state_q == asc_pkg::ASC_HOLD) begin
			state_d = asc_pkg::ASC_INIT;
		end else if (go_lead) begin
			state_d = asc_pkg::ASC_LEAD;
		end else if (step) begin
			case (state_q)
				asc_pkg::ASC_INIT:  state_d = asc_pkg::ASC_LEAD;
				asc_pkg::ASC_LEAD:  state_d = chop_enable_bit ? asc_pkg::ASC_CDLY
					: asc_pkg::ASC_CONT;
				asc_pkg::ASC_CONT:  state_d = asc_pkg::ASC_CONT;
				asc_pkg::ASC_CDLY:  state_d = asc_pkg::ASC_CCONV;
				asc_pkg::ASC_CCONV: state_d = asc_pkg::ASC_CDLY;
				default:            state_d = asc_pkg::ASC_HOLD;
			endcase
		end
	end

	// main sequence
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= asc_pkg::ASC_POR;
		end else begin
			state_q <= state_d;
		end
	end

	// modulator period counter, cleared on every state change
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (go_hold || go_lead || step) begin
			cnt_q <= '0;
		end else if (mod_tick && !in_por && state_q != asc_pkg::ASC_HOLD) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// continuous-mode outputs since the last reset, saturating
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_cnt_q <= '0;
		end else if (go_hold) begin
			out_cnt_q <= '0;
		end else if (cont_out && out_cnt_q != 2'h3) begin
			out_cnt_q <= out_cnt_q + 2'h1;
		end
	end

	// internal chop conversions since the last restart, saturating
	always_ff @(posedge mclk) begin
		if (rst) begin
			pair_cnt_q <= '0;
		end else if (go_hold || go_lead) begin
			pair_cnt_q <= '0;
		end else if (chop_swap && pair_cnt_q != 2'h3) begin
			pair_cnt_q <= pair_cnt_q + 2'h1;
		end
	end

	// polarity returns to normal on every reset or restart
	always_ff @(posedge mclk) begin
		if (rst) begin
			chop_polarity <= 1'b0;
		end else if (go_hold || go_lead) begin
			chop_polarity <= 1'b0;
		end else if (chop_swap) begin
			chop_polarity <= ~chop_polarity;
		end
	end

	// reset, restart and swap all clear the filter
	always_ff @(posedge mclk) begin
		if (rst) begin
			filter_reset <= 1'b0;
		end else begin
			filter_reset <= go_hold || go_lead || chop_swap;
		end
	end

	// one result per conversion in continuous mode, per swap once a pair exists
	always_ff @(posedge mclk) begin
		if (rst) begin
			result_d <= 1'b0;
		end else begin
			result_d <= cont_out || (chop_swap
				&& pair_cnt_q >= 2'(asc_pkg::CHOP_PAIR_MIN - 1));
		end
	end

	// data-ready low during power-on and reset, then a short low per result
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_ready_n_cnt_q   <= '0;
			data_ready_n <= 1'b0;
		end else if (state_q == asc_pkg::ASC_POR || state_q == asc_pkg::ASC_HOLD) begin
			data_ready_n_cnt_q   <= '0;
			data_ready_n <= 1'b0;
		end else if (result_d) begin
			data_ready_n_cnt_q   <= CW'(DATA_READY_N_W);
			data_ready_n <= 1'b0;
		end else if (data_ready_n_cnt_q > CW'(1)) begin
			data_ready_n_cnt_q <= data_ready_n_cnt_q - CW'(1);
		end else begin
			data_ready_n_cnt_q   <= '0;
			data_ready_n <= 1'b1;
		end
	end

	// path selection and side outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			modulator_run <= 1'b0;
		end else begin
			modulator_run <= state_q == asc_pkg::ASC_CONT || state_q == asc_pkg::ASC_CDLY
				|| state_q == asc_pkg::ASC_CCONV;
		end
	end

	// the fast path stays up through the strobe of the second output, so the
	// path flags always describe the result that is being announced
	always_ff @(posedge mclk) begin
		if (rst) begin
			fast_path_enable <= 1'b0;
		end else begin
			fast_path_enable <= state_q == asc_pkg::ASC_CONT && !chop_q
				&& (out_cnt_q < 2'(asc_pkg::FAST_SAMPLES)
				|| (result_d && out_cnt_q == 2'(asc_pkg::FAST_SAMPLES)));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sinc_path_select <= 1'b0;
		end else begin
			sinc_path_select <= chop_q || out_cnt_q > 2'(asc_pkg::FAST_SAMPLES)
				|| (!result_d && out_cnt_q == 2'(asc_pkg::FAST_SAMPLES));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pair_average <= 1'b0;
		end else begin
			pair_average <= chop_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			result_strobe <= 1'b0;
		end else begin
			result_strobe <= result_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_cal_active <= 1'b0;
		end else begin
			phase_cal_active <= phase_cal_request && !chop_enable_bit;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			test_signal_active <= 1'b0;
		end else begin
			test_signal_active <= test_signal_request && !chop_enable_bit;
		end
	end
endmodule : asc_sequencer

// File: verif/asc_sequencer_assertions.sv
// port assertions for the sequencer
`timescale 1ns/1ps
module asc_sequencer_assertions (
	input wire logic	mclk,
	input wire logic	rst,
	input wire logic	chop_enable_bit,
	input wire logic	phase_cal_request,
	input wire logic	data_ready_n,
	input wire logic	modulator_run,
	input wire logic	fast_path_enable,
	input wire logic	sinc_path_select,
	input wire logic	chop_polarity,
	input wire logic	filter_reset,
	input wire logic	result_strobe,
	input wire logic	phase_cal_active,
	input wire logic	test_signal_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_low; !data_ready_n[*8] ##1 data_ready_n; endsequence
	property p_pulse; result_strobe |-> s_low; endproperty
	a_pulse: assert property (p_pulse) else $error("ready pulse width");
	property p_fall; result_strobe |-> $fell(data_ready_n); endproperty
	a_fall: assert property (p_fall) else $error("strobe without ready edge");
	property p_run; result_strobe |-> modulator_run; endproperty
	a_run: assert property (p_run) else $error("result while idle");
	property p_start; $rose(modulator_run) |-> data_ready_n; endproperty
	a_start: assert property (p_start) else $error("run before ready high");
	property p_excl; fast_path_enable |-> !sinc_path_select; endproperty
	a_excl: assert property (p_excl) else $error("both filter paths");
	property p_test; chop_enable_bit |=> !test_signal_active; endproperty
	a_test: assert property (p_test) else $error("test signal in chop");
	property p_phase; chop_enable_bit |=> !phase_cal_active; endproperty
	a_phase: assert property (p_phase) else $error("phase cal in chop");
	property p_phon; !chop_enable_bit && phase_cal_request |=> phase_cal_active; endproperty
	a_phon: assert property (p_phon) else $error("phase cal lost");
	property p_swap; chop_enable_bit && $changed(chop_polarity) |-> ##[0:1] filter_reset;
	endproperty
	a_swap: assert property (p_swap) else $error("swap without filter reset");
endmodule : asc_sequencer_assertions
bind asc_sequencer asc_sequencer_assertions chk (.mclk, .rst, .chop_enable_bit,
	.phase_cal_request, .data_ready_n, .modulator_run, .fast_path_enable, .sinc_path_select,
	.chop_polarity, .filter_reset, .result_strobe, .phase_cal_active, .test_signal_active);

// File: verif/asc_host_model.sv
// host model: modulator clock source and ready edge counter
`timescale 1ns/1ps
module asc_host_model (
	input wire logic	mclk,
	input wire logic	clk_en,
	input wire logic	data_ready_n,
	output logic		master_clock_in,
	output int		data_ready_n_falls
);
	logic [1:0]	div_q;
	logic		data_ready_n_q;
	initial begin
		div_q = 2'h0;
		data_ready_n_q = 1'b0;
		data_ready_n_falls = 0;
	end
	// clock stands low until enabled, then one modulator period per four mclk
	always @(posedge mclk) div_q <= clk_en ? div_q + 2'h1 : 2'h0;
	assign master_clock_in = div_q[1];
	// falls counted so the host can drop the first two results
	always @(negedge mclk) begin
		if (data_ready_n_q === 1'b1 && data_ready_n === 1'b0) data_ready_n_falls++;
		data_ready_n_q <= data_ready_n;
	end
endmodule : asc_host_model

// File: verif/asc_sequencer_tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
module asc_sequencer_tb;
	localparam int OSR = 16;
	localparam int TP = 4;
	localparam int ST = (300 + OSR) * TP;
	logic	mclk, rst, sync_reset_n, supply_settled, command_reset, chop_enable_bit, clk_en;
	logic	phase_cal_request, test_signal_request, master_clock_in, data_ready_n;
	logic	modulator_run, fast_path_enable, sinc_path_select, chop_polarity, filter_reset;
	logic	pair_average, result_strobe, phase_cal_active, test_signal_active;
	logic [asc_pkg::DLY_FIELD_W-1:0]	chop_settle_delay_field;
	logic [asc_pkg::OSR_W-1:0]		osr;
	int	mismatches, checks, data_ready_n_falls, t;
	// chop, phase req, test req, phase expected, test expected
	logic [4:0]	rows [4] = '{5'h0f, 5'h1c, 5'h0a, 5'h05};
	asc_sequencer #(.OSR_RESET(OSR), .RST_MIN_W(4)) dut (.mclk, .rst, .master_clock_in,
		.sync_reset_n, .supply_settled, .command_reset, .chop_enable_bit,
		.chop_settle_delay_field, .osr, .phase_cal_request, .test_signal_request,
		.data_ready_n, .modulator_run, .fast_path_enable, .sinc_path_select, .chop_polarity,
		.filter_reset, .pair_average, .result_strobe, .phase_cal_active, .test_signal_active);
	asc_host_model host (.mclk, .clk_en, .data_ready_n, .master_clock_in, .data_ready_n_falls);
	task automatic test_done;
		if (mismatches == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, s);
		end
	endtask : chk
	task automatic wait_strobe(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (result_strobe !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			mismatches++;
			test_done();
		end
	endtask : wait_strobe
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		{rst, sync_reset_n} = 2'h3;
		{supply_settled, command_reset, chop_enable_bit, clk_en} = 4'h0;
		{phase_cal_request, test_signal_request} = 2'h0;
		chop_settle_delay_field = '0;
		osr = asc_pkg::OSR_W'(OSR);
		mismatches = 0;
		checks = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		supply_settled <= 1'b1;
		#1 chk("data_ready_n_rst", data_ready_n, 0);
		repeat (4) @(posedge mclk);
		#1 chk("data_ready_n_por", data_ready_n, 1);
		foreach (rows[i]) begin
			@(posedge mclk);
			{chop_enable_bit, phase_cal_request, test_signal_request} <= rows[i][4:2];
			repeat (3) @(posedge mclk);
			#1 chk("phase", phase_cal_active, rows[i][1]);
			chk("test", test_signal_active, rows[i][0]);
		end
		@(posedge mclk);
		clk_en <= 1'b1;
		wait_strobe(t);
		chk("first", 32'(t >= ST - 4 && t <= ST + 16), 1);
		chk("fast1", fast_path_enable, 1);
		wait_strobe(t);
		chk("period", t, OSR * TP);
		chk("fast2", fast_path_enable, 1);
		wait_strobe(t);
		chk("sinc", sinc_path_select, 1);
		@(posedge mclk);
		command_reset <= 1'b1;
		@(posedge mclk);
		command_reset <= 1'b0;
		chk("falls", data_ready_n_falls, 3);
		wait_strobe(t);
		chk("cmd", 32'(t >= ST - 8 && t <= ST + 16), 1);
		chk("cmdfast", fast_path_enable, 1);
		@(posedge mclk);
		chop_enable_bit <= 1'b1;
		repeat (8) @(posedge mclk);
		sync_reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		sync_reset_n <= 1'b1;
		wait_strobe(t);
		t = t - (44 + 2 * (2 + 3 * OSR)) * TP;
		chk("chop1", 32'(t >= -12 && t <= 24), 1);
		wait_strobe(t);
		chop_settle_delay_field <= 4'h1;
		chk("chop_per", t, (2 + 3 * OSR) * TP);
		chk("pair", pair_average, 1);
		@(posedge mclk);
		sync_reset_n <= 1'b0;
		repeat (20) @(posedge mclk);
		#1 chk("hold", data_ready_n, 0);
		chk("hold_run", modulator_run, 0);
		test_done();
	end
endmodule : asc_sequencer_tb
